// ==== bench/mds_chk.sv ====
`timescale 1ns/100ps
module mds_chk
(
  // clock and reset
  input wire       pclk,
  input wire       presetn,
  // watched ports
  input wire       motor_run_req,
  input wire       contactor_on,
  input wire       dip_active,
  input wire       dip_duration_error,
  input wire       inhibit_low_protection,
  input wire       bus_fault,
  input wire [3:0] src_start,
  input wire [3:0] src_stop,
  input wire [2:0] active_mode,
  input wire       start_cmd,
  input wire       stop_cmd
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_inhibit_dip: assert property (
    inhibit_low_protection == dip_active) else $error("inhibit mismatch");
  a_dip_needs_run: assert property (
    $rose(dip_active) |-> $past(motor_run_req)) else $error("dip idle");
  a_err_after_drop: assert property (
    $rose(dip_duration_error) |-> !contactor_on) else $error("err on");
  a_on_needs_req: assert property (
    $rose(contactor_on) |-> $past(motor_run_req)) else $error("on no req");
  a_drop_in_dip: assert property (
    $fell(contactor_on) && motor_run_req |-> ##[0:2] dip_active)
    else $error("drop outside dip");
  a_mode_onehot: assert property (
    $onehot(active_mode)) else $error("mode not one-hot");
  a_fault_local: assert property (
    bus_fault [*2] |-> active_mode == 3'b010) else $error("fault mode");
  a_start_has_src: assert property (
    start_cmd |-> $past(|src_start)) else $error("start from nothing");
  a_stop_has_src: assert property (
    stop_cmd |-> $past(|src_stop)) else $error("stop from nothing");

  c_drop: cover property ($fell(contactor_on));
  c_auto: cover property (active_mode == 3'b001 && start_cmd);
  c_local2: cover property (active_mode == 3'b100);
endmodule // mds_chk

bind mds_top mds_chk i_chk
(
  .pclk, .presetn, .motor_run_req, .contactor_on, .dip_active,
  .dip_duration_error, .inhibit_low_protection, .bus_fault, .src_start,
  .src_stop, .active_mode, .start_cmd, .stop_cmd
);

// ==== bench/mds_ctl_model.sv ====
`timescale 1ns/100ps
module mds_ctl_model
(
  // clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // cyclic telegram byte 0 and link state
  input  wire [7:0] tel_byte0,
  input  wire       link_lost,
  // toward the block
  output reg        remote_request,
  output reg        cyc_start,
  output reg        bus_fault
);
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      remote_request <= 1'b0;
      cyc_start      <= 1'b0;
      bus_fault      <= 1'b0;
    end
    else
    begin
      remote_request <= tel_byte0[5];
      cyc_start      <= tel_byte0[0];
      bus_fault      <= link_lost;
    end
  end
endmodule // mds_ctl_model

// ==== bench/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err_seen, cyc_start, start_cmd, stop_cmd;
  logic [15:0] supply_voltage = 16'h0;
  logic        ext_low_voltage = 0, motor_run_req = 0, panel_menu_active = 0;
  logic        contactor_on, dip_active, dip_duration_error;
  logic        inhibit_low_protection, bus_fault, remote_request;
  logic [1:0]  am_present = 2'h0, force_local_sel = 2'h0;
  logic [1:0]  am_missing_fault, am_temp_warn, am_temp_trip;
  logic [47:0] am1_values = 48'h0, am2_values = 48'hffff_ffff_ffff;
  logic [2:0]  multifunction_inputs = 3'h0, tb_src = 3'h0, active_mode;
  logic [3:0]  src_start, src_stop = 4'h0;
  logic [7:0]  tel_byte0 = 8'h0;
  logic        link_lost = 0;
  int          error_cnt = 0, num_checks = 0;
  assign src_start = {tb_src, cyc_start};
  wire [31:0]  am_flags = {26'h0, am_missing_fault, am_temp_warn,
                           am_temp_trip};

  mds_top i_dut
  (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .supply_voltage, .ext_low_voltage, .motor_run_req,
    .contactor_on, .dip_active, .dip_duration_error,
    .inhibit_low_protection, .am_present, .am1_values, .am2_values,
    .am_missing_fault, .am_temp_warn, .am_temp_trip, .bus_fault,
    .remote_request, .panel_menu_active, .multifunction_inputs,
    .force_local_sel, .src_start, .src_stop, .active_mode, .start_cmd,
    .stop_cmd
  );
  mds_ctl_model i_ctl
  (
    .pclk, .presetn, .tel_byte0, .link_lost, .remote_request, .cyc_start,
    .bus_fault
  );

  initial
  begin
    forever #10 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // bounded wait for the relay output to reach a level
  task automatic wait_on(input logic v, input int lim);
    int n;
    n = 0;
    while (contactor_on !== v)
    begin
      n++;
      if (n > lim)
      begin
        error_cnt++;
        close_out();
      end
      @(posedge pclk);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 100)
      begin
        error_cnt++;
        close_out();
      end
      @(posedge pclk);
    end
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    apb(1'b0, 12'h014, 32'h0);
    chk(rd, 32'h0000_0404);
    apb(1'b1, 12'h040, 32'h5);
    chk({31'h0, err_seen}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, 12'h000, 32'h7);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h7);
  endtask

  // fault, force-local, remote bit -> one-hot mode
  task automatic t_mode;
    logic [5:0] row [5] = '{6'b100_010, 6'b111_010, 6'b011_100,
                            6'b001_001, 6'b000_010};
    foreach (row[i])
    begin
      link_lost <= row[i][5];
      multifunction_inputs <= {2'b00, row[i][4]};
      tel_byte0 <= {2'b00, row[i][3], 5'h0};
      ticks(4);
      chk({29'h0, active_mode}, {29'h0, row[i][2:0]});
    end
    tel_byte0 <= 8'h20;
    panel_menu_active <= 1'b1;
    ticks(4);
    chk({29'h0, active_mode}, 32'h2);
    panel_menu_active <= 1'b0;
    ticks(4);
    chk({29'h0, active_mode}, 32'h1);
    tel_byte0 <= 8'h00;
  endtask

  // remote bit, cyclic start, other sources -> expected start
  task automatic t_gate;
    logic [5:0] row [5] = '{6'b10_111_0, 6'b11_000_1, 6'b01_000_0,
                            6'b00_001_1, 6'b00_010_1};
    apb(1'b1, 12'h020, 32'h00f6_f6f1);
    foreach (row[i])
    begin
      tel_byte0 <= {2'b00, row[i][5], 4'h0, row[i][4]};
      tb_src <= row[i][3:1];
      ticks(4);
      chk({31'h0, start_cmd}, {31'h0, row[i][0]});
    end
    tb_src <= 3'h0;
    src_stop <= 4'h8;
    ticks(3);
    chk({31'h0, stop_cmd}, 32'h1);
    src_stop <= 4'h0;
  endtask

  task automatic t_analog;
    apb(1'b1, 12'h014, 32'h0000_0407);
    apb(1'b1, 12'h018, 32'h0175_0143);
    am1_values <= {16'h0100, 16'h0150, 16'h0143};
    ticks(4);
    chk(am_flags, 32'h14);
    am_present <= 2'b01;
    am1_values <= {16'h0176, 16'h0100, 16'h0100};
    ticks(4);
    chk(am_flags, 32'h05);
    apb(1'b1, 12'h014, 32'h0000_0405);
    ticks(4);
    chk(am_flags, 32'h00);
    apb(1'b0, 12'h028, 32'h0);
    chk(rd, 32'h0000_0100);
  endtask

  task automatic t_dip;
    apb(1'b1, 12'h004, 32'h1);
    apb(1'b1, 12'h008, 32'h3);
    apb(1'b1, 12'h00c, 32'h1);
    apb(1'b1, 12'h000, 32'h7);
    motor_run_req <= 1'b1;
    wait_on(1'b1, 20);
    ext_low_voltage <= 1'b1;
    ticks(200);
    chk({30'h0, dip_active, inhibit_low_protection}, 32'h3);
    ext_low_voltage <= 1'b0;
    ticks(20);
    chk({31'h0, contactor_on}, 32'h1);
    ext_low_voltage <= 1'b1;
    ticks(4);
    chk({31'h0, contactor_on}, 32'h0);
    ext_low_voltage <= 1'b0;
    ticks(4);
    chk({31'h0, contactor_on}, 32'h0);
    wait_on(1'b1, 60000);
    chk({31'h0, contactor_on}, 32'h1);
  endtask

  // zero window and duration, no autorestart
  task automatic t_dip_long;
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h008, 32'h0);
    apb(1'b1, 12'h000, 32'h1);
    ext_low_voltage <= 1'b1;
    ticks(4);
    chk({31'h0, contactor_on}, 32'h0);
    chk({31'h0, dip_duration_error}, 32'h1);
    ext_low_voltage <= 1'b0;
    ticks(4);
    chk({31'h0, contactor_on}, 32'h0);
    motor_run_req <= 1'b0;
    ticks(4);
    chk({31'h0, dip_duration_error}, 32'h0);
    motor_run_req <= 1'b1;
    wait_on(1'b1, 20);
    chk({31'h0, contactor_on}, 32'h1);
  endtask

  initial
  begin
    ticks(16);
    presetn <= 1'b1;
    ticks(1);
    t_regs();
    t_mode();
    t_gate();
    t_analog();
    t_dip();
    t_dip_long();
    close_out();
  end
endmodule // tb_top

// ==== hw/mds_regs.vh ====
`ifndef MDS_REGS_VH
`define MDS_REGS_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define MDS_OFF_CTRL      12'h000
`define MDS_OFF_DIP_WIN   12'h004
`define MDS_OFF_DIP_DUR   12'h008
`define MDS_OFF_DIP_DLY   12'h00c
`define MDS_OFF_DIP_LVL   12'h010
`define MDS_OFF_AM_CFG    12'h014
`define MDS_OFF_AM1_LVL   12'h018
`define MDS_OFF_AM2_LVL   12'h01c
`define MDS_OFF_PERM      12'h020
`define MDS_OFF_STATUS    12'h024
`define MDS_OFF_AM1_VAL   12'h028
`define MDS_OFF_AM2_VAL   12'h02c
`define MDS_OFF_TMAX      12'h030
// ----------------------------------------------------------------
// ctrl fields
// ----------------------------------------------------------------
`define MDS_CTRL_DIP_EN   0
`define MDS_CTRL_DIP_RCL  1
`define MDS_CTRL_AR_EN    2
`define MDS_CTRL_SRC_VM   3
`define MDS_CTRL_RST      32'h0000_0000
// ----------------------------------------------------------------
// analog module config fields, per module 8 bits at index*8
// ----------------------------------------------------------------
`define MDS_AM_EN         0
`define MDS_AM_TEMP       1
`define MDS_AM_MISS_REAC  2
`define MDS_AM_CFG_RST    32'h0000_0404
// ----------------------------------------------------------------
// scales and timing
// ----------------------------------------------------------------
`define MDS_KELVIN_ZERO_C 16'h0111
`define MDS_ANALOG_FULL   16'h6c00
`define MDS_CLK_HZ        50000000
`define MDS_TICK_MS       1
`define MDS_TICK_CYC      (`MDS_CLK_HZ / 1000 * `MDS_TICK_MS)
`define MDS_RCL_MS        1000
// ----------------------------------------------------------------
// modes
// ----------------------------------------------------------------
`define MDS_MODE_AUTO     3'b001
`define MDS_MODE_FIRST_LOCAL_SETTING     3'b010
`define MDS_MODE_SECOND_LOCAL_SETTING     3'b100
`endif

// ==== hw/mds_top.v ====
`timescale 1ns/100ps
module mds_top
(
  // apb
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // voltage dip sources
  input  wire [15:0] supply_voltage,
  input  wire        ext_low_voltage,
  // motor request and contactor
  input  wire        motor_run_req,
  output reg         contactor_on,
  output reg         dip_active,
  output reg         dip_duration_error,
  output wire        inhibit_low_protection,
  // analog modules: three 16-bit channels each
  input  wire [1:0]  am_present,
  input  wire [47:0] am1_values,
  input  wire [47:0] am2_values,
  output reg  [1:0]  am_missing_fault,
  output reg  [1:0]  am_temp_warn,
  output reg  [1:0]  am_temp_trip,
  // mode selection
  input  wire        bus_fault,
  input  wire        remote_request,
  input  wire        panel_menu_active,
  input  wire [2:0]  multifunction_inputs,
  input  wire [1:0]  force_local_sel,
  // command sources: 0 cyclic bus, 1 di, 2 panel, 3 acyclic bus
  input  wire [3:0]  src_start,
  input  wire [3:0]  src_stop,
  output reg  [2:0]  active_mode,
  output reg         start_cmd,
  output reg         stop_cmd
);
`include "mds_regs.vh"
  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  reg [31:0] ctrl;
  reg [15:0] win_ms;
  reg [15:0] dur_ms;
  reg [15:0] dly_ms;
  reg [31:0] dip_lvl;
  reg [31:0] am_cfg;
  reg [31:0] am1_lvl;
  reg [31:0] am2_lvl;
  reg [23:0] perm;
  wire       wr_en = psel & penable & pwrite;
  wire       rd_hit;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~rd_hit;
  assign rd_hit  = (paddr <= `MDS_OFF_TMAX) && (paddr[1:0] == 2'b00);
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl    <= `MDS_CTRL_RST;
      win_ms  <= 16'h0000;
      dur_ms  <= 16'h0000;
      dly_ms  <= 16'h0000;
      dip_lvl <= 32'h0000_0000;
      am_cfg  <= `MDS_AM_CFG_RST;
      am1_lvl <= 32'hffff_ffff;
      am2_lvl <= 32'hffff_ffff;
      perm    <= 24'h000000;
    end
    else if (wr_en)
    begin
      if (paddr == `MDS_OFF_CTRL)
        ctrl <= pwdata;
      else if (paddr == `MDS_OFF_DIP_WIN)
        win_ms <= pwdata[15:0];
      else if (paddr == `MDS_OFF_DIP_DUR)
        dur_ms <= pwdata[15:0];
      else if (paddr == `MDS_OFF_DIP_DLY)
        dly_ms <= pwdata[15:0];
      else if (paddr == `MDS_OFF_DIP_LVL)
        dip_lvl <= pwdata;
      else if (paddr == `MDS_OFF_AM_CFG)
        am_cfg <= pwdata;
      else if (paddr == `MDS_OFF_AM1_LVL)
        am1_lvl <= pwdata;
      else if (paddr == `MDS_OFF_AM2_LVL)
        am2_lvl <= pwdata;
      else if (paddr == `MDS_OFF_PERM)
        perm <= pwdata[23:0];
    end
  end
  // --------------------------------------------------------------
  // millisecond tick
  // --------------------------------------------------------------
  reg [15:0] tick_cnt;
  reg        tick;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_cnt <= 16'h0000;
      tick     <= 1'b0;
    end
    else if (tick_cnt == `MDS_TICK_CYC - 1)
    begin
      tick_cnt <= 16'h0000;
      tick     <= 1'b1;
    end
    else
    begin
      tick_cnt <= tick_cnt + 16'h0001;
      tick     <= 1'b0;
    end
  end
  // --------------------------------------------------------------
  // dip detection
  // --------------------------------------------------------------
  reg  low_v;
  wire dip_now = ctrl[`MDS_CTRL_SRC_VM] ? low_v : ext_low_voltage;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      low_v <= 1'b0;
    else if (!low_v && supply_voltage < dip_lvl[15:0])
      low_v <= 1'b1;
    else if (low_v && supply_voltage >= dip_lvl[31:16])
      low_v <= 1'b0;
  end
  assign inhibit_low_protection = dip_active;
  // --------------------------------------------------------------
  // dip state machine
  // --------------------------------------------------------------
  localparam ST_RUN  = 4'b0001;
  localparam ST_DIP  = 4'b0010;
  localparam ST_OFF  = 4'b0100;
  localparam ST_WAIT = 4'b1000;
  reg  [3:0]  state;
  reg  [15:0] dip_ms;
  reg  [15:0] rest_ms;
  reg  [15:0] since_ms;
  reg         since_valid;
  wire        dip_en  = ctrl[`MDS_CTRL_DIP_EN];
  wire        ar_en   = ctrl[`MDS_CTRL_AR_EN];
  wire        rapid   = ctrl[`MDS_CTRL_DIP_RCL] && since_valid &&
                        since_ms < `MDS_RCL_MS;
  wire        dip_rise = dip_now && !dip_active && dip_en;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state              <= ST_RUN;
      dip_active         <= 1'b0;
      dip_ms             <= 16'h0000;
      rest_ms            <= 16'h0000;
      since_ms           <= 16'h0000;
      since_valid        <= 1'b0;
      contactor_on       <= 1'b0;
      dip_duration_error <= 1'b0;
    end
    else
    begin
      if (dip_rise)
      begin
        since_ms    <= 16'h0000;
        since_valid <= 1'b1;
      end
      else if (tick && since_valid && since_ms < `MDS_RCL_MS)
        since_ms <= since_ms + 16'h0001;
      if (!motor_run_req)
        dip_duration_error <= 1'b0;
      case (state)
        ST_RUN:
        begin
          contactor_on <= motor_run_req;
          dip_active   <= 1'b0;
          if (dip_rise && motor_run_req)
          begin
            dip_active <= 1'b1;
            dip_ms     <= 16'h0000;
            if (rapid)
            begin
              contactor_on <= 1'b0;
              state        <= ST_OFF;
            end
            else
              state <= ST_DIP;
          end
        end
        ST_DIP, ST_OFF:
        begin
          if (tick && dip_active)
            dip_ms <= dip_ms + 16'h0001;
          if (state == ST_DIP && dip_ms >= win_ms)
          begin
            contactor_on <= 1'b0;
            state        <= ST_OFF;
          end
          if (dip_active && dip_ms >= dur_ms && state == ST_OFF)
            dip_duration_error <= 1'b1;
          if (!dip_now)
          begin
            dip_active <= 1'b0;
            rest_ms    <= 16'h0000;
            if (state == ST_DIP && dip_ms < win_ms)
              state <= ST_RUN;
            else if (dip_active && ar_en && dip_ms < dur_ms &&
                     motor_run_req)
              state <= ST_WAIT;
            // no restart: relay stays off until the request drops
            else if (!motor_run_req)
              state <= ST_RUN;
          end
        end
        ST_WAIT:
        begin
          contactor_on <= 1'b0;
          if (tick)
            rest_ms <= rest_ms + 16'h0001;
          if (!motor_run_req)
            state <= ST_RUN;
          else if (rest_ms >= dly_ms)
            state <= ST_RUN;
        end
        default:
          state <= ST_RUN;
      endcase
    end
  end
  // --------------------------------------------------------------
  // analog modules
  // --------------------------------------------------------------
  function [15:0] max3;
    input [47:0] v;
    reg   [15:0] m;
    begin
      m = (v[15:0] > v[31:16]) ? v[15:0] : v[31:16];
      max3 = (m > v[47:32]) ? m : v[47:32];
    end
  endfunction
  wire [47:0] am_vals [0:1];
  wire [31:0] am_lvls [0:1];
  reg  [15:0] tmax    [0:1];
  assign am_vals[0] = am1_values;
  assign am_vals[1] = am2_values;
  assign am_lvls[0] = am1_lvl;
  assign am_lvls[1] = am2_lvl;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_am
      wire [7:0] cfg  = am_cfg[gi*8 +: 8];
      wire       en   = cfg[`MDS_AM_EN];
      wire       temp = cfg[`MDS_AM_TEMP];
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          tmax[gi]             <= 16'h0000;
          am_missing_fault[gi] <= 1'b0;
          am_temp_warn[gi]     <= 1'b0;
          am_temp_trip[gi]     <= 1'b0;
        end
        else
        begin
          tmax[gi] <= max3(am_vals[gi]);
          am_missing_fault[gi] <= en & ~am_present[gi] &
                                  cfg[`MDS_AM_MISS_REAC];
          // channel one levels cover all channels; universal mode
          // only reports raw values
          am_temp_warn[gi] <= en & temp &
                              (tmax[gi] > am_lvls[gi][15:0]);
          am_temp_trip[gi] <= en & temp &
                              (tmax[gi] > am_lvls[gi][31:16]);
        end
      end
    end
  endgenerate
  // --------------------------------------------------------------
  // mode selection and command gating
  // --------------------------------------------------------------
  wire force_local = multifunction_inputs[force_local_sel] &&
                     force_local_sel != 2'b11;
  reg [2:0] next_mode;
  always @*
  begin
    if (bus_fault)
      next_mode = `MDS_MODE_FIRST_LOCAL_SETTING;
    else if (force_local)
      next_mode = `MDS_MODE_SECOND_LOCAL_SETTING;
    else if (remote_request && !panel_menu_active)
      next_mode = `MDS_MODE_AUTO;
    else
      next_mode = `MDS_MODE_FIRST_LOCAL_SETTING;
  end
  // perm: auto [7:0], local 1 [15:8], local 2 [23:16];
  // low nibble start enables, high nibble stop enables
  wire [7:0] sel_perm = (active_mode == `MDS_MODE_AUTO) ? perm[7:0] :
                        (active_mode == `MDS_MODE_SECOND_LOCAL_SETTING) ? perm[23:16] :
                        perm[15:8];
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      active_mode <= `MDS_MODE_FIRST_LOCAL_SETTING;
      start_cmd   <= 1'b0;
      stop_cmd    <= 1'b0;
    end
    else
    begin
      active_mode <= next_mode;
      start_cmd   <= |(src_start & sel_perm[3:0]);
      stop_cmd    <= |(src_stop & sel_perm[7:4]);
    end
  end
  // --------------------------------------------------------------
  // read mux
  // --------------------------------------------------------------
  always @*
  begin
    if (paddr == `MDS_OFF_CTRL)
      prdata = ctrl;
    else if (paddr == `MDS_OFF_DIP_WIN)
      prdata = {16'h0000, win_ms};
    else if (paddr == `MDS_OFF_DIP_DUR)
      prdata = {16'h0000, dur_ms};
    else if (paddr == `MDS_OFF_DIP_DLY)
      prdata = {16'h0000, dly_ms};
    else if (paddr == `MDS_OFF_DIP_LVL)
      prdata = dip_lvl;
    else if (paddr == `MDS_OFF_AM_CFG)
      prdata = am_cfg;
    else if (paddr == `MDS_OFF_AM1_LVL)
      prdata = am1_lvl;
    else if (paddr == `MDS_OFF_AM2_LVL)
      prdata = am2_lvl;
    else if (paddr == `MDS_OFF_PERM)
      prdata = {8'h00, perm};
    else if (paddr == `MDS_OFF_STATUS)
      prdata = {16'h0000, active_mode, am_temp_trip, am_temp_warn,
                am_missing_fault, dip_duration_error, dip_active,
                contactor_on, state};
    else if (paddr == `MDS_OFF_AM1_VAL)
      prdata = {16'h0000, am1_values[15:0]};
    else if (paddr == `MDS_OFF_AM2_VAL)
      prdata = {16'h0000, am2_values[15:0]};
    else if (paddr == `MDS_OFF_TMAX)
      prdata = {tmax[1], tmax[0]};
    else
      prdata = 32'h0000_0000;
  end
endmodule // mds_top
